// file: logic/srw_supervisor.sv
// supervisor top: reset generation, reset stretch, watchdog, power-fail pass
// assumes comparator results arrive as asynchronous digital levels
`timescale 1ns/100ps

module srw_supervisor #(
  parameter bit HAS_WATCHDOG = 1'b1,
  parameter int unsigned STRETCH_CYCLES = srw_pkg::RESET_STRETCH_CYCLES,
  parameter int unsigned WD_CYCLES = srw_pkg::WD_TIMEOUT_CYCLES,
  parameter int unsigned DEB_CYCLES = srw_pkg::DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supply_low_in,
  input wire logic manual_reset_n,
  input wire logic activity_strobe_in,
  input wire logic strobe_float_in,
  input wire logic powerfail_sense_in,
  output logic reset_n,
  output logic reset_hi,
  output logic watchdog_timeout_n,
  output logic powerfail_warn_n
);

  localparam int unsigned SW = $clog2(STRETCH_CYCLES + 1);
  localparam int unsigned WW = $clog2(WD_CYCLES + 1);
  localparam logic [SW-1:0] STRETCH_TERM = SW'(STRETCH_CYCLES - 1);
  localparam logic [WW-1:0] WD_TERM = WW'(WD_CYCLES);

  logic [srw_pkg::SYNC_W-1:0] sync_a;
  logic [srw_pkg::SYNC_W-1:0] sync_b;
  logic mr_sync_a;
  logic mr_sync_b;
  logic mr_db;
  logic supply_low;
  logic strobe;
  logic strobe_prev;
  logic strobe_floating;
  logic pf_above;
  logic hold_cond;
  logic rst_active;
  logic [SW-1:0] stretch_cnt;
  logic stretch_done;
  logic [WW-1:0] wd_cnt;
  logic wd_edge;
  logic wd_clear;
  logic wd_expired;
  logic next_wd_timeout_n;

  // ==========================================================
  // input synchronisers: every input pin except rst_n passes two flops before use
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync_a <= '0;
      sync_b <= '0;
      mr_sync_a <= 1'b1;
      mr_sync_b <= 1'b1;
    end
    else
    begin
      sync_a[srw_pkg::SYNC_SUPPLY] <= supply_low_in;
      sync_a[srw_pkg::SYNC_STROBE] <= activity_strobe_in;
      sync_a[srw_pkg::SYNC_FLOAT] <= strobe_float_in;
      sync_a[srw_pkg::SYNC_PF] <= powerfail_sense_in;
      sync_b <= sync_a;
      mr_sync_a <= manual_reset_n;
      mr_sync_b <= mr_sync_a;
    end
  end

  // synchronised names
  assign supply_low = sync_b[srw_pkg::SYNC_SUPPLY];
  assign strobe = sync_b[srw_pkg::SYNC_STROBE];
  assign strobe_floating = sync_b[srw_pkg::SYNC_FLOAT];
  assign pf_above = sync_b[srw_pkg::SYNC_PF];

  // ==========================================================
  // manual reset debounce
  srw_debounce #(
    .DEB_CYCLES(DEB_CYCLES)
  ) u_mr_debounce (
    .mclk(mclk),
    .rst_n(rst_n),
    .level_in(mr_sync_b),
    .level_out(mr_db)
  );

  // ==========================================================
  // reset generation and stretch
  // the watchdog output is deliberately absent here: only an external
  // strap from the timeout pin to the manual input can make it reset
  assign hold_cond = supply_low | ~mr_db;
  assign stretch_done = (stretch_cnt == STRETCH_TERM);

  // counter held at zero during a hold, then counts out the stretch
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rst_active <= srw_pkg::RESET_ACTIVE_RESET;
      stretch_cnt <= '0;
    end
    else if (hold_cond)
    begin
      rst_active <= 1'b1;
      stretch_cnt <= '0;
    end
    else if (rst_active && stretch_done)
    begin
      rst_active <= 1'b0;
      stretch_cnt <= '0;
    end
    else if (rst_active)
    begin
      stretch_cnt <= stretch_cnt + SW'(1);
    end
  end

  // outputs straight off the flop; the high output is absent on watchdog builds
  assign reset_n = ~rst_active;
  assign reset_hi = HAS_WATCHDOG ? 1'b0 : rst_active;

  // ==========================================================
  // watchdog
  // the processor must toggle the strobe inside the timeout; the floating strobe input
  // and supply low both hold the count at zero, but only the floating input tolerates a slower strobe
  assign wd_edge = strobe ^ strobe_prev;
  assign wd_clear = !HAS_WATCHDOG || strobe_floating || wd_edge || supply_low;
  assign wd_expired = (wd_cnt == WD_TERM);
  assign next_wd_timeout_n = !HAS_WATCHDOG ||
    (!supply_low && (strobe_floating || !wd_expired));

  // count saturates at the terminal value so the timeout stays until an edge
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wd_cnt <= '0;
      strobe_prev <= 1'b0;
      watchdog_timeout_n <= srw_pkg::WD_TIMEOUT_N_RESET;
    end
    else
    begin
      strobe_prev <= strobe;
      watchdog_timeout_n <= next_wd_timeout_n;
      if (wd_clear)
      begin
        wd_cnt <= '0;
      end
      else if (!wd_expired)
      begin
        wd_cnt <= wd_cnt + WW'(1);
      end
    end
  end

  // ==========================================================
  // power-fail pass-through, touches nothing else
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      powerfail_warn_n <= srw_pkg::PF_WARN_N_RESET;
    end
    else
    begin
      powerfail_warn_n <= pf_above;
    end
  end

  // ==========================================================
  // checks
  property p_mr_forces_reset;
    @(posedge mclk) disable iff (!rst_n)
    !mr_db |=> !reset_n && stretch_cnt == '0;
  endproperty
  a_mr_forces_reset: assert property (p_mr_forces_reset)
    else $error("manual reset low did not assert reset");

  property p_supply_forces_reset;
    @(posedge mclk) disable iff (!rst_n)
    $rose(supply_low_in) ##2 supply_low |=> !reset_n;
  endproperty
  a_supply_forces_reset: assert property (p_supply_forces_reset)
    else $error("supply low did not assert reset within three cycles");

  property p_stretch_holds;
    @(posedge mclk) disable iff (!rst_n)
    rst_active && !hold_cond && !stretch_done |=> rst_active;
  endproperty
  a_stretch_holds: assert property (p_stretch_holds)
    else $error("reset released before the stretch elapsed");

  property p_release_at_term;
    @(posedge mclk) disable iff (!rst_n)
    $fell(rst_active) |-> $past(stretch_cnt) == STRETCH_TERM && !$past(hold_cond);
  endproperty
  a_release_at_term: assert property (p_release_at_term)
    else $error("reset released at the wrong count");

  property p_high_reset_inverse;
    @(posedge mclk) disable iff (!rst_n)
    reset_hi == (HAS_WATCHDOG ? 1'b0 : ~reset_n);
  endproperty
  a_high_reset_inverse: assert property (p_high_reset_inverse)
    else $error("active-high reset is not the inverse");

  property p_edge_restarts;
    @(posedge mclk) disable iff (!rst_n)
    wd_edge |=> wd_cnt == '0 ##1 (wd_cnt <= WW'(1));
  endproperty
  a_edge_restarts: assert property (p_edge_restarts)
    else $error("strobe edge did not restart the watchdog");

  property p_timeout_fires;
    @(posedge mclk) disable iff (!rst_n)
    HAS_WATCHDOG && wd_expired && !supply_low && !strobe_floating |=> !watchdog_timeout_n;
  endproperty
  a_timeout_fires: assert property (p_timeout_fires)
    else $error("watchdog expiry did not drive the timeout low");

  property p_supply_forces_timeout;
    @(posedge mclk) disable iff (!rst_n)
    HAS_WATCHDOG && supply_low |=> !watchdog_timeout_n;
  endproperty
  a_supply_forces_timeout: assert property (p_supply_forces_timeout)
    else $error("supply low did not drive the timeout low");

  property p_float_suspends;
    @(posedge mclk) disable iff (!rst_n)
    strobe_floating && !supply_low |=> watchdog_timeout_n && wd_cnt == '0;
  endproperty
  a_float_suspends: assert property (p_float_suspends)
    else $error("floating strobe did not suspend the watchdog");

  property p_wd_no_reset;
    @(posedge mclk) disable iff (!rst_n)
    $rose(rst_active) |-> $past(hold_cond);
  endproperty
  a_wd_no_reset: assert property (p_wd_no_reset)
    else $error("reset asserted without a supply or manual cause");

  property p_powerfail_follows;
    @(posedge mclk) disable iff (!rst_n)
    $past(rst_n, 3) |-> powerfail_warn_n == $past(powerfail_sense_in, 3);
  endproperty
  a_powerfail_follows: assert property (p_powerfail_follows)
    else $error("power-fail warning does not follow the sense input");

endmodule : srw_supervisor

// file: shared/srw_pkg.sv
// constants shared by the supervisor and its debounce stage
// assumes a single free-running clock at the rate named below
package srw_pkg;

  // ==========================================================
  // clock rate
  localparam int unsigned MCLK_HZ = 100_000_000;
  localparam int unsigned MCLK_PERIOD_NS = 10;

  // ==========================================================
  // reset stretch after supply or manual release
  localparam int unsigned RESET_STRETCH_MS = 200;
  // longest/least time alike: exact multiple of the period
  localparam int unsigned RESET_STRETCH_CYCLES = (MCLK_HZ / 1000) * RESET_STRETCH_MS;

  // ==========================================================
  // watchdog timeout, 1.6 s held in milliseconds
  localparam int unsigned WD_TIMEOUT_MS = 1600;
  localparam int unsigned WD_TIMEOUT_CYCLES = (MCLK_HZ / 1000) * WD_TIMEOUT_MS;

  // ==========================================================
  // manual reset debounce window, well below the 150 ns pulse floor x10
  localparam int unsigned DEBOUNCE_NS = 1000;
  localparam int unsigned DEBOUNCE_CYCLES =
    (DEBOUNCE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // ==========================================================
  // reset values
  localparam logic MR_DEBOUNCED_RESET = 1'b1;
  localparam logic PF_WARN_N_RESET = 1'b1;
  localparam logic WD_TIMEOUT_N_RESET = 1'b1;
  localparam logic RESET_ACTIVE_RESET = 1'b1;

  // ==========================================================
  // synchroniser bit positions
  localparam int unsigned SYNC_W = 4;
  localparam int unsigned SYNC_SUPPLY = 0;
  localparam int unsigned SYNC_STROBE = 1;
  localparam int unsigned SYNC_FLOAT = 2;
  localparam int unsigned SYNC_PF = 3;

endpackage : srw_pkg

// file: logic/srw_debounce.sv
// debounce stage for the manual reset input
// assumes its input is already synchronised to mclk
`timescale 1ns/100ps

module srw_debounce #(
  parameter int unsigned DEB_CYCLES = srw_pkg::DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic level_in,
  output logic level_out
);

  localparam int unsigned CW = $clog2(DEB_CYCLES + 1);
  localparam logic [CW-1:0] TERM = CW'(DEB_CYCLES - 1);

  logic [CW-1:0] stable_cnt;
  logic differs;
  logic at_term;

  // ==========================================================
  // compare and terminal decode
  assign differs = level_in ^ level_out;
  assign at_term = (stable_cnt == TERM);

  // counter runs only while the input disagrees; any agreement restarts it,
  // so a glitch shorter than the window never moves the output
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stable_cnt <= '0;
      level_out <= srw_pkg::MR_DEBOUNCED_RESET;
    end
    else if (!differs)
    begin
      stable_cnt <= '0;
    end
    else if (at_term)
    begin
      stable_cnt <= '0;
      level_out <= level_in;
    end
    else
    begin
      stable_cnt <= stable_cnt + CW'(1);
    end
  end

  // ==========================================================
  // checks
  property p_deb_stable;
    @(posedge mclk) disable iff (!rst_n)
    $changed(level_out) |-> $past(stable_cnt) == TERM && $past(differs);
  endproperty
  a_deb_stable: assert property (p_deb_stable)
    else $error("debounced level moved before the window elapsed");

endmodule : srw_debounce

// file: bench/srw_proc_model.sv
// behavioural processor that feeds the supervisor its activity strobe
// assumes the same mclk as the supervisor; run is set by the bench
`timescale 1ns/100ps

module srw_proc_model #(
  parameter int unsigned TOGGLE_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic run,
  output logic activity_strobe_in
);
  int unsigned cnt = 0;

  // ==========================================================
  // strobe toggling
  // toggle well inside the watchdog window; idle holds the count at the
  // wrap point so a resumed run toggles on the very next edge
  initial activity_strobe_in = 1'b0;
  always @(posedge mclk)
  begin
    if (!run)
    begin
      cnt <= TOGGLE_CYCLES - 1;
    end
    else if (cnt >= TOGGLE_CYCLES - 1)
    begin
      cnt <= 0;
      activity_strobe_in <= ~activity_strobe_in;
    end
    else
    begin
      cnt <= cnt + 1;
    end
  end
endmodule : srw_proc_model

// file: bench/tb.sv
// self-checking bench: watchdog variant and high-reset variant side by side
// assumes short safe counts: stretch 20, watchdog 40, debounce 3 cycles
`timescale 1ns/100ps

module tb;
  logic mclk, rst_n, supply_low, manual_n, float_in, sense, run;
  logic strobe, rn1, rh1, wn1, pn1, rn2, rh2, wn2, pn2;
  logic [5:0] notes[$];
  logic [5:0] cur_note;
  // short counts keep the run brief; the design scales them by parameter
  localparam int unsigned SIM_STRETCH = 20;
  localparam int unsigned SIM_WD = 40;
  localparam int unsigned SIM_DEB = 3;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  event sample_ev;

  // ==========================================================
  // clock, stimulus defaults and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    rst_n = 1'b0;
    supply_low = 1'b0;
    manual_n = 1'b1;
    float_in = 1'b0;
    sense = 1'b1;
    run = 1'b1;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  srw_proc_model srw_proc_model_inst (.mclk(mclk), .run(run), .activity_strobe_in(strobe));

  srw_supervisor #(.HAS_WATCHDOG(1'b1), .STRETCH_CYCLES(SIM_STRETCH), .WD_CYCLES(SIM_WD),
    .DEB_CYCLES(SIM_DEB)) srw_supervisor_inst (.mclk(mclk), .rst_n(rst_n),
    .supply_low_in(supply_low), .manual_reset_n(manual_n), .activity_strobe_in(strobe),
    .strobe_float_in(float_in), .powerfail_sense_in(sense), .reset_n(rn1),
    .reset_hi(rh1), .watchdog_timeout_n(wn1), .powerfail_warn_n(pn1));

  // second build variant sees identical pins
  srw_supervisor #(.HAS_WATCHDOG(1'b0), .STRETCH_CYCLES(SIM_STRETCH), .WD_CYCLES(SIM_WD),
    .DEB_CYCLES(SIM_DEB)) srw_supervisor_hi_inst (.mclk(mclk), .rst_n(rst_n),
    .supply_low_in(supply_low), .manual_reset_n(manual_n), .activity_strobe_in(strobe),
    .strobe_float_in(float_in), .powerfail_sense_in(sense), .reset_n(rn2),
    .reset_hi(rh2), .watchdog_timeout_n(wn2), .powerfail_warn_n(pn2));

  // ==========================================================
  // comparison, note keeping and closing report
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t outputs %b expected %b", $time, seen, exp);
    end
  endtask : check

  // note = {reset_n, reset_hi, wdt_n, warn_n, variant reset_hi, variant wdt_n}
  task automatic expect_out(input logic rn, input logic wn, input logic pn);
    notes.push_back({rn, 1'b0, wn, pn, ~rn, 1'b1});
    ->sample_ev;
  endtask : expect_out

  // watcher: oldest note against the settled outputs
  always @(sample_ev)
  begin
    cur_note = notes.pop_front();
    check({rn1, rh1, wn1, pn1, rh2, wn2}, cur_note);
    check({4'h0, rn2, pn2}, {4'h0, cur_note[5], cur_note[2]});
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_cyc

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(25));
    wait_cyc(5);
    expect_out(1'b0, 1'b1, 1'b1);
    wait_cyc(5);
    rst_n = 1'b1;
    wait_cyc(10);
    expect_out(1'b0, 1'b1, 1'b1);
    wait_cyc(20);
    expect_out(1'b1, 1'b1, 1'b1);
    // supply drop: reset and timeout output both low, variant high reset up
    supply_low = 1'b1;
    wait_cyc(4);
    expect_out(1'b0, 1'b0, 1'b1);
    wait_cyc(60);
    expect_out(1'b0, 1'b0, 1'b1);
    supply_low = 1'b0;
    wait_cyc(10);
    expect_out(1'b0, 1'b1, 1'b1);
    wait_cyc(20);
    expect_out(1'b1, 1'b1, 1'b1);
    // two-cycle glitch must not start a reset
    manual_n = 1'b0;
    wait_cyc(2);
    manual_n = 1'b1;
    wait_cyc(10);
    expect_out(1'b1, 1'b1, 1'b1);
    manual_n = 1'b0;
    wait_cyc(10);
    expect_out(1'b0, 1'b1, 1'b1);
    manual_n = 1'b1;
    wait_cyc(2);
    manual_n = 1'b0;
    wait_cyc(2);
    manual_n = 1'b1;
    wait_cyc(11);
    expect_out(1'b0, 1'b1, 1'b1);
    wait_cyc(20);
    expect_out(1'b1, 1'b1, 1'b1);
    // strobe stops: timeout only after the window, reset untouched
    run = 1'b0;
    wait_cyc(20);
    expect_out(1'b1, 1'b1, 1'b1);
    wait_cyc(50);
    expect_out(1'b1, 1'b0, 1'b1);
    run = 1'b1;
    wait_cyc(10);
    expect_out(1'b1, 1'b1, 1'b1);
    wait_cyc(200);
    expect_out(1'b1, 1'b1, 1'b1);
    // floating strobe suspends the watchdog
    run = 1'b0;
    float_in = 1'b1;
    wait_cyc(150);
    expect_out(1'b1, 1'b1, 1'b1);
    float_in = 1'b0;
    run = 1'b1;
    wait_cyc(5);
    // random sense levels, other outputs must not move
    repeat (16)
    begin
      sense = 1'($urandom % 2);
      wait_cyc(4);
      expect_out(1'b1, 1'b1, sense);
    end
    sense = 1'b1;
    manual_n = 1'b0;
    wait_cyc(10);
    expect_out(1'b0, 1'b1, 1'b1);
    sense = 1'b0;
    wait_cyc(4);
    expect_out(1'b0, 1'b1, 1'b0);
    wait_cyc(2);
    end_sim();
  end
endmodule : tb
